/* File: sif_pkg.sv */
// Package with the constants shared by the system input/output block.
package sif_pkg;

   // Clock and input filter timing.
   localparam int unsigned CLK_KHZ        = 250000;
   localparam int unsigned FILTER_TIME_MS = 10;
   localparam int unsigned FILTER_CYCLES  = FILTER_TIME_MS * CLK_KHZ;
   localparam int          FILTER_CW      = 23;

   // Port widths.
   localparam int NUM_GP   = 4;
   localparam int NUM_CMD  = 4;
   localparam int NUM_STAT = 4;
   localparam int NUM_EVT  = 9;

   // Register byte addresses.
   localparam logic [7:0] ADDR_CTRL       = 8'h00;
   localparam logic [7:0] ADDR_GP_OUT     = 8'h04;
   localparam logic [7:0] ADDR_SYS_STATUS = 8'h08;
   localparam logic [7:0] ADDR_IN_STATE   = 8'h0C;
   localparam logic [7:0] ADDR_IRQ_STATUS = 8'h10;
   localparam logic [7:0] ADDR_IRQ_CLEAR  = 8'h14;
   localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h18;

   // Control register fields.
   localparam int CTRL_ESTOP_CLEAR_BIT = 0;
   localparam int CTRL_ALT_MODE_BIT    = 1;

   // Input state register fields.
   localparam int IN_GP_LSB    = 0;
   localparam int IN_CMD_LSB   = 4;
   localparam int IN_ESTOP_BIT = 8;

   // Command order inside the command vector and the command field of the input state register.
   localparam int CMD_ORIGIN = 0;
   localparam int CMD_START  = 1;
   localparam int CMD_STOP   = 2;
   localparam int CMD_RESET  = 3;

   // Reset values.
   localparam logic [1:0]  CTRL_RESET  = 2'h0;
   localparam logic [3:0]  GP_RESET    = 4'h0;
   localparam logic [3:0]  STAT_RESET  = 4'h0;
   localparam logic [8:0]  EVT_RESET   = 9'h000;

   // Bus responses.
   localparam logic [1:0]  RESP_OKAY   = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;

endpackage : sif_pkg

/* File: sif_input_filter.sv */
// Per-input stability filter that accepts a new level only after it held for the full filter time.
`timescale 1ns/1ps
module sif_input_filter #(
   parameter int unsigned FILTER_CYCLES = sif_pkg::FILTER_CYCLES
) (
   // Clock and reset.
   input  wire logic aclk,
   input  wire logic aresetn,
   // Raw and recognised level.
   input  wire logic raw_in,
   output logic      level_out
);

   logic                           sample_ff;
   logic                           level_ff;
   logic [sif_pkg::FILTER_CW-1:0]  count_ff;

   localparam logic [sif_pkg::FILTER_CW-1:0] LAST = sif_pkg::FILTER_CW'(FILTER_CYCLES - 1);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sample_ff <= 1'b0;
      end else begin
         sample_ff <= raw_in;
      end
   end

   // A pulse shorter than the filter time restarts the count and never reaches the output.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         count_ff <= '0;
         level_ff <= 1'b0;
      end else if (sample_ff == level_ff) begin
         count_ff <= '0;
      end else if (count_ff == LAST) begin
         count_ff <= '0;
         level_ff <= sample_ff;
      end else begin
         count_ff <= count_ff + 1'b1;
      end
   end

   assign level_out = level_ff;

endmodule : sif_input_filter

/* File: sif_system_io.sv */
// System and general-purpose input/output port block with input filters, status outputs and emergency stop contact.
// Notes on behaviour
// - A change on any filtered general or command input is acted on only after it has stood through the 10 ms filter.
// - An input pulse shorter than 10 ms is dropped and leaves the recognised level unchanged.
// - An open emergency stop loop is treated as an emergency stop, so a missing loop stops the controller.
// - During emergency stop the general outputs keep their levels unless the clear option is set.
// - The stop contact reports the stop state: normally-open side closed and normally-closed side open in stop.
// - Four status outputs show running, error, positioning complete and return-to-origin complete.
// - A mode bit gives the general inputs and outputs alternative functions instead of plain port use.
`timescale 1ns/1ps
module sif_system_io #(
   parameter int unsigned FILTER_CYCLES = sif_pkg::FILTER_CYCLES
) (
   // Clock and reset.
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // AXI4-Lite write address channel.
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [7:0]  s_axi_awaddr,
   // AXI4-Lite write data channel.
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   // AXI4-Lite write response channel.
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   output logic [1:0]       s_axi_bresp,
   // AXI4-Lite read address channel.
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   input  wire logic [7:0]  s_axi_araddr,
   // AXI4-Lite read data channel.
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   // General-purpose port pins.
   input  wire logic [3:0]  gp_in,
   output logic [3:0]       gp_out,
   // System command inputs.
   input  wire logic        origin_return_cmd_in,
   input  wire logic        start_cmd_in,
   input  wire logic        stop_cmd_in,
   input  wire logic        reset_cmd_in,
   // System status outputs.
   output logic             running_out,
   output logic             error_out,
   output logic             positioning_done_out,
   output logic             origin_return_done_out,
   // Emergency stop loop and contact.
   input  wire logic        estop_loop_positive,
   input  wire logic        estop_loop_negative,
   output logic             estop_contact_normally_open,
   output logic             estop_contact_normally_closed,
   output logic             estop_contact_common,
   // Interrupt.
   output logic             irq
);

   localparam int NG = sif_pkg::NUM_GP;
   localparam int NC = sif_pkg::NUM_CMD;
   localparam int NE = sif_pkg::NUM_EVT;

   // Byte-lane merge of a write into an existing register word.
   function automatic logic [31:0] merge_strb(input logic [31:0] old_v, input logic [31:0] new_v,
                                              input logic [3:0] strb);
      logic [31:0] res;
      res = old_v;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return res;
   endfunction : merge_strb

   // Decode of a mapped register address.
   function automatic logic addr_mapped(input logic [7:0] a);
      return (a == sif_pkg::ADDR_CTRL) || (a == sif_pkg::ADDR_GP_OUT) || (a == sif_pkg::ADDR_SYS_STATUS) ||
             (a == sif_pkg::ADDR_IN_STATE) || (a == sif_pkg::ADDR_IRQ_STATUS) ||
             (a == sif_pkg::ADDR_IRQ_CLEAR) || (a == sif_pkg::ADDR_IRQ_ENABLE);
   endfunction : addr_mapped

   // ---------------- Input filters ----------------
   logic [NG-1:0] gp_filt;
   logic [NC-1:0] cmd_raw;
   logic [NC-1:0] cmd_filt;

   assign cmd_raw[sif_pkg::CMD_ORIGIN] = origin_return_cmd_in;
   assign cmd_raw[sif_pkg::CMD_START]  = start_cmd_in;
   assign cmd_raw[sif_pkg::CMD_STOP]   = stop_cmd_in;
   assign cmd_raw[sif_pkg::CMD_RESET]  = reset_cmd_in;

   for (genvar g = 0; g < NG; g++) begin : g_gp_filt
      sif_input_filter #(.FILTER_CYCLES(FILTER_CYCLES)) u_filt (
         .aclk      (aclk),
         .aresetn   (aresetn),
         .raw_in    (gp_in[g]),
         .level_out (gp_filt[g])
      );
   end

   for (genvar c = 0; c < NC; c++) begin : g_cmd_filt
      sif_input_filter #(.FILTER_CYCLES(FILTER_CYCLES)) u_filt (
         .aclk      (aclk),
         .aresetn   (aresetn),
         .raw_in    (cmd_raw[c]),
         .level_out (cmd_filt[c])
      );
   end

   // ---------------- Registers ----------------
   logic [1:0]    ctrl_ff;
   logic [NG-1:0] gp_reg_ff;
   logic [3:0]    stat_reg_ff;
   logic [NE-1:0] irq_status_ff;
   logic [NE-1:0] irq_enable_ff;
   logic          estop_ff;
   logic [NG-1:0] gp_prev_ff;
   logic [NC-1:0] cmd_prev_ff;
   logic          estop_prev_ff;

   logic          alt_mode;
   logic [NC-1:0] cmd_act;
   logic [NE-1:0] events;

   assign alt_mode = ctrl_ff[sif_pkg::CTRL_ALT_MODE_BIT];

   // In the alternative mode the general inputs double as the four commands.
   assign cmd_act = alt_mode ? (cmd_filt | gp_filt) : cmd_filt;

   // Events: any general input change outside the alternative mode, a rising command edge, and any change of the stop state.
   assign events = {estop_ff ^ estop_prev_ff, cmd_act & ~cmd_prev_ff, alt_mode ? 4'h0 : (gp_filt ^ gp_prev_ff)};

   // ---------------- Emergency stop ----------------
   // The loop counts as closed only while current can flow from positive to negative side.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         estop_ff      <= 1'b1;
         estop_prev_ff <= 1'b1;
      end else begin
         estop_ff      <= ~(estop_loop_positive & ~estop_loop_negative);
         estop_prev_ff <= estop_ff;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         estop_contact_normally_open   <= 1'b1;
         estop_contact_normally_closed <= 1'b0;
         estop_contact_common          <= 1'b1;
      end else begin
         estop_contact_normally_open   <= estop_ff;
         estop_contact_normally_closed <= ~estop_ff;
         estop_contact_common          <= 1'b1;
      end
   end

   // ---------------- Pin outputs ----------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         gp_out <= sif_pkg::GP_RESET;
      end else if (estop_ff && ctrl_ff[sif_pkg::CTRL_ESTOP_CLEAR_BIT]) begin
         gp_out <= sif_pkg::GP_RESET;
      end else if (!estop_ff) begin
         gp_out <= alt_mode ? stat_reg_ff : gp_reg_ff;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         running_out            <= 1'b0;
         error_out              <= 1'b0;
         positioning_done_out   <= 1'b0;
         origin_return_done_out <= 1'b0;
      end else begin
         running_out            <= stat_reg_ff[0];
         error_out              <= stat_reg_ff[1];
         positioning_done_out   <= stat_reg_ff[2];
         origin_return_done_out <= stat_reg_ff[3];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         gp_prev_ff  <= '0;
         cmd_prev_ff <= '0;
      end else begin
         gp_prev_ff  <= gp_filt;
         cmd_prev_ff <= cmd_act;
      end
   end

   // ---------------- AXI4-Lite write path ----------------
   logic [7:0]  waddr_ff;
   logic [31:0] wdata_ff;
   logic [3:0]  wstrb_ff;
   logic        aw_held_ff;
   logic        w_held_ff;
   logic        do_write;
   logic        clr_write;

   assign do_write  = aw_held_ff && w_held_ff && !s_axi_bvalid;
   assign clr_write = do_write && (waddr_ff == sif_pkg::ADDR_IRQ_CLEAR);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_ff    <= 1'b0;
         w_held_ff     <= 1'b0;
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         waddr_ff      <= '0;
         wdata_ff      <= '0;
         wstrb_ff      <= '0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_ff    <= 1'b1;
            s_axi_awready <= 1'b0;
            waddr_ff      <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_ff    <= 1'b1;
            s_axi_wready <= 1'b0;
            wdata_ff     <= s_axi_wdata;
            wstrb_ff     <= s_axi_wstrb;
         end
         if (do_write) begin
            aw_held_ff <= 1'b0;
            w_held_ff  <= 1'b0;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= sif_pkg::RESP_OKAY;
      end else if (do_write) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= addr_mapped(waddr_ff) ? sif_pkg::RESP_OKAY : sif_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_ff       <= sif_pkg::CTRL_RESET;
         gp_reg_ff     <= sif_pkg::GP_RESET;
         stat_reg_ff   <= sif_pkg::STAT_RESET;
         irq_enable_ff <= sif_pkg::EVT_RESET;
      end else if (do_write) begin
         case (waddr_ff)
            sif_pkg::ADDR_CTRL: begin
               ctrl_ff <= 2'(merge_strb(32'(ctrl_ff), wdata_ff, wstrb_ff));
            end
            sif_pkg::ADDR_GP_OUT: begin
               gp_reg_ff <= 4'(merge_strb(32'(gp_reg_ff), wdata_ff, wstrb_ff));
            end
            sif_pkg::ADDR_SYS_STATUS: begin
               stat_reg_ff <= 4'(merge_strb(32'(stat_reg_ff), wdata_ff, wstrb_ff));
            end
            sif_pkg::ADDR_IRQ_ENABLE: begin
               irq_enable_ff <= NE'(merge_strb(32'(irq_enable_ff), wdata_ff, wstrb_ff));
            end
            default: begin
               ctrl_ff <= ctrl_ff;
            end
         endcase
      end
   end

   // Sticky events: a new event in the clearing cycle survives the clear.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_status_ff <= sif_pkg::EVT_RESET;
      end else begin
         irq_status_ff <= (irq_status_ff & ~(clr_write ? NE'(merge_strb(32'h0, wdata_ff, wstrb_ff)) : '0))
                          | events;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(irq_status_ff & irq_enable_ff);
      end
   end

   // ---------------- AXI4-Lite read path ----------------
   logic [31:0] rd_word;

   always_comb begin
      rd_word = 32'h0000_0000;
      case (s_axi_araddr)
         sif_pkg::ADDR_CTRL:       rd_word[1:0] = ctrl_ff;
         sif_pkg::ADDR_GP_OUT:     rd_word[3:0] = gp_reg_ff;
         sif_pkg::ADDR_SYS_STATUS: rd_word[3:0] = stat_reg_ff;
         sif_pkg::ADDR_IN_STATE: begin
            rd_word[sif_pkg::IN_GP_LSB +: NG]  = gp_filt;
            rd_word[sif_pkg::IN_CMD_LSB +: NC] = cmd_filt;
            rd_word[sif_pkg::IN_ESTOP_BIT]     = estop_ff;
         end
         sif_pkg::ADDR_IRQ_STATUS: rd_word[NE-1:0] = irq_status_ff;
         sif_pkg::ADDR_IRQ_ENABLE: rd_word[NE-1:0] = irq_enable_ff;
         default:                  rd_word = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= sif_pkg::RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rdata   <= rd_word;
         s_axi_rresp   <= addr_mapped(s_axi_araddr) ? sif_pkg::RESP_OKAY : sif_pkg::RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
      end
   end

endmodule : sif_system_io

/* File: sif_plc_model.sv */
// Far-side controller model driving the filtered inputs and the stop loop.
`timescale 1ns/1ps
module sif_plc_model #(
   parameter int unsigned FC = 8
) (
   // Clock.
   input  wire logic  aclk,
   // Driven pins.
   output logic [3:0] gp_in,
   output logic [3:0] cmd_in,
   output logic       estop_loop_positive,
   output logic       estop_loop_negative
);
   initial begin
      gp_in = 4'h0;
      cmd_in = 4'h0;
      estop_loop_positive = 1'b1;
      estop_loop_negative = 1'b0;
   end
   // Bit 8 of the level opens the stop loop.
   task automatic drive(input logic [8:0] v);
      @(posedge aclk);
      gp_in <= v[3:0];
      cmd_in <= v[7:4];
      estop_loop_positive <= ~v[8];
      estop_loop_negative <= 1'b0;
      repeat (3 * FC + 2) @(posedge aclk);
   endtask : drive
   // Too short on purpose; only the glitch scenario asks for it.
   task automatic glitch(input int idx);
      @(posedge aclk);
      gp_in[idx] <= ~gp_in[idx];
      repeat (FC - 3) @(posedge aclk);
      gp_in[idx] <= ~gp_in[idx];
      repeat (3 * FC + 2) @(posedge aclk);
   endtask : glitch
endmodule : sif_plc_model

/* File: sif_system_io_props.sv */
// Checker for bus answers, status pins, general outputs and stop contact.
`timescale 1ns/1ps
module sif_system_io_props #(
   parameter int unsigned FILTER_CYCLES = 8
) (
   // Clock, reset and bus.
   input wire logic       aclk,
   input wire logic       aresetn,
   input wire logic       s_axi_awvalid,
   input wire logic       s_axi_awready,
   input wire logic       s_axi_wvalid,
   input wire logic       s_axi_wready,
   input wire logic       s_axi_bvalid,
   input wire logic       s_axi_arvalid,
   input wire logic       s_axi_arready,
   input wire logic       s_axi_rvalid,
   // Pins.
   input wire logic [3:0] gp_out,
   input wire logic       running_out,
   input wire logic       error_out,
   input wire logic       positioning_done_out,
   input wire logic       origin_return_done_out,
   input wire logic       estop_loop_positive,
   input wire logic       estop_loop_negative,
   input wire logic       estop_contact_normally_open,
   input wire logic       estop_contact_normally_closed,
   input wire logic       estop_contact_common
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   logic       open_w;
   logic [3:0] stat_w;
   logic       no_w;
   assign open_w = !estop_loop_positive || estop_loop_negative;
   assign stat_w = {origin_return_done_out, positioning_done_out, error_out, running_out};
   assign no_w = estop_contact_normally_open;
   sequence s_open3; open_w [*3]; endsequence
   sequence s_shut3; !open_w [*3]; endsequence
   sequence s_stop_edge; $changed(no_w) || $past(no_w) != $past(no_w, 2); endsequence
   a_contact_pair: assert property (estop_contact_normally_closed == !no_w)
      else $error("stop contact sides not opposite");
   a_common_high: assert property (estop_contact_common)
      else $error("stop contact common low");
   a_stop_open: assert property (s_open3 |=> no_w)
      else $error("open loop without stop");
   a_stop_shut: assert property (s_shut3 |=> !no_w)
      else $error("closed loop still in stop");
   a_gp_frozen: assert property (no_w && $past(no_w) |-> $stable(gp_out) || gp_out == 4'h0)
      else $error("general outputs moved in stop");
   a_gp_cause: assert property ($changed(gp_out) |-> (s_axi_bvalid || $past(s_axi_bvalid)) or s_stop_edge)
      else $error("general outputs changed without cause");
   a_status_cause: assert property ($changed(stat_w) |-> s_axi_bvalid || $past(s_axi_bvalid))
      else $error("status pins changed without write");
   a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
      else $error("write response late");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read data late");
   a_aw_blocked: assert property (s_axi_bvalid |-> !s_axi_awready)
      else $error("write address open during response");
endmodule : sif_system_io_props
bind sif_system_io sif_system_io_props #(.FILTER_CYCLES(FILTER_CYCLES)) sif_system_io_props_inst (.*);

/* File: tb_top.sv */
// Self-checking bench for the system port block.
`timescale 1ns/1ps
module tb_top;
   localparam int unsigned FC = 8;
   logic        aclk = 1'b0, aresetn = 1'b0;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, rd, seed = 32'hFB45779E;
   logic [3:0]  s_axi_wstrb = 4'hF, gp_in, cmd_in, gp_out;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rsp, cts;
   logic [31:0] s_axi_rdata;
   logic        estop_loop_positive, estop_loop_negative;
   logic        running_out, error_out, positioning_done_out, origin_return_done_out;
   logic        estop_contact_normally_open, estop_contact_normally_closed, estop_contact_common;
   int          mismatches = 0, checked = 0, m_gp = 0, m_stat = 0, m_in = 0, m_evt = 0, m_alt = 0;
   int          vq[$] = '{32'hF0, 32'h0F};
   logic [7:0]  raddr[6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h14, 8'h18};
   assign cts = {estop_contact_normally_open, estop_contact_normally_closed};
   always #2 aclk = ~aclk;
   sif_system_io #(.FILTER_CYCLES(FC)) sif_system_io_inst (.*, .origin_return_cmd_in(cmd_in[0]),
      .start_cmd_in(cmd_in[1]), .stop_cmd_in(cmd_in[2]), .reset_cmd_in(cmd_in[3]));
   sif_plc_model #(.FC(FC)) sif_plc_model_inst (.*);
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : xs
   function automatic int ce(input int v);
      return m_alt ? (((v >> 4) | v) & 'hF) : ((v >> 4) & 'hF);
   endfunction : ce
   task automatic summarize();
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : summarize
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      checked++;
      if (s !== e) begin
         mismatches++;
         $display("Error %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   // A bus answer that never comes ends the run instead of hanging it.
   task automatic tmo(input int n);
      if (n >= 64) begin
         mismatches++;
         summarize();
      end
   endtask : tmo
   task automatic settle();
      repeat (2) @(negedge aclk);
   endtask : settle
   task automatic axw(input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid && n < 64);
      rsp = s_axi_bresp;
      s_axi_bready <= 1'b0;
      tmo(n);
   endtask : axw
   task automatic axr(input logic [7:0] a);
      int n;
      n = 0;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid && n < 64);
      rd = s_axi_rdata;
      rsp = s_axi_rresp;
      s_axi_rready <= 1'b0;
      tmo(n);
   endtask : axr
   task automatic drv(input int v);
      int p;
      p = m_in;
      fork
         sif_plc_model_inst.drive(9'(v));
         begin
            repeat (FC / 2) @(posedge aclk);
            axr(8'h0C);
            chk("in_state_early", rd, (p & 'hFF) | (v & 'h100));
         end
      join
      m_in = v;
      if (m_alt == 0) m_evt |= (p ^ v) & 'hF;
      m_evt |= ((ce(v) & ~ce(p)) << 4) | ((p ^ v) & 'h100);
      axr(8'h0C);
      chk("in_state", rd, v);
      axr(8'h10);
      chk("irq_status", rd, m_evt);
   endtask : drv
   task automatic irqs();
      settle();
      chk("irq", irq, 32'(m_evt != 0));
      axw(8'h18, 32'h0);
      settle();
      chk("irq_masked", irq, 0);
      axw(8'h18, 32'h1FF);
      axw(8'h14, 32'(m_evt));
      m_evt = 0;
      settle();
      chk("irq_cleared", irq, 0);
   endtask : irqs
   initial begin
      int v;
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (4) @(posedge aclk);
      foreach (raddr[i]) begin
         axr(raddr[i]);
         chk("reset_value", rd, 0);
      end
      chk("contact_run", cts, 2'b01);
      axw(8'h14, 32'h1FF);
      axr(8'h10);
      chk("status_cleared", rd, 0);
      axw(8'h1C, xs());
      chk("unmapped_wresp", rsp, 2'h2);
      axr(8'h1C);
      chk("unmapped_rdata", rd, 0);
      chk("unmapped_rresp", rsp, 2'h2);
      axw(8'h0C, 32'hFFFFFFFF);
      axr(8'h0C);
      chk("in_state_ro", rd, 0);
      for (int i = 0; i < 4; i++) begin
         v = xs();
         axw(8'h04, v);
         axw(8'h08, v >> 4);
         m_gp = v & 'hF;
         m_stat = (v >> 4) & 'hF;
         axr(8'h08);
         chk("sys_status", rd, m_stat);
         chk("status_pins", {origin_return_done_out, positioning_done_out, error_out, running_out}, m_stat);
         chk("gp_out", gp_out, m_gp);
      end
      $display("register test done");
      axw(8'h18, 32'h1FF);
      vq.push_back(xs() & 'hFF);
      vq.push_back(0);
      foreach (vq[i]) begin
         drv(vq[i]);
         irqs();
      end
      v = m_in;
      sif_plc_model_inst.glitch(1);
      axr(8'h0C);
      chk("glitch_level", rd, v);
      axr(8'h10);
      chk("glitch_event", rd, 0);
      $display("filter test done");
      v = m_gp;
      drv(m_in | 'h100);
      chk("contact_stop", cts, 2'b10);
      axw(8'h04, ~v & 'hF);
      m_gp = ~v & 'hF;
      settle();
      chk("gp_held", gp_out, v);
      axw(8'h00, 32'h1);
      settle();
      chk("gp_cleared", gp_out, 0);
      drv(m_in & 'hFF);
      settle();
      chk("gp_resumed", gp_out, m_gp);
      chk("contact_back", cts, 2'b01);
      irqs();
      $display("stop test done");
      axw(8'h00, 32'h2);
      m_alt = 1;
      settle();
      chk("alt_gp_out", gp_out, m_stat);
      drv('h2);
      irqs();
      axw(8'h00, 32'h0);
      $display("mode test done");
      summarize();
   end
endmodule : tb_top
